// >>> design/clock_gen.sv
// Clock generator control: source select, core gear, peripheral gate, two clock outputs.
// Assumes oscillator levels arrive asynchronously and are sampled on clk_sys; clocks leave
// the block as one-cycle tick enables, clock outputs as pin levels with an output enable.
//
// The address-and-strobe port and the address map are this design's own decisions.
`include "clock_gen_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module clock_gen #(
    parameter int SLOW_WAIT_LONG = `CG_SLOW_WAIT_LONG,
    parameter int SLOW_WAIT_SHORT = `CG_SLOW_WAIT_SHORT
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire clock_gen_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Oscillator levels, bit 0 fast, bit 1 slow
    input wire logic [1:0] osc_level,
    output logic fast_osc_run,
    output logic slow_osc_run,
    output logic [1:0] fast_osc_freq_sel,
    // Power control from the core
    input wire logic halt_req,
    input wire logic sleep_req,
    input wire logic irq_wake,
    input wire logic ext_wake,
    input wire logic rtc_run_bit,
    // Clock ticks
    output logic sys_clk_tick,
    output logic core_clock_tick,
    output logic periph_clk_tick,
    output logic slow_timer_tick,
    // Clock output pins
    output clock_gen_pkg::clk_pin_t clk_out_a,
    output clock_gen_pkg::clk_pin_t clk_out_b
);

    // Fast wait in cycles: code 0 is 64, each step halves
    function automatic logic [15:0] fast_wait(input logic [1:0] code);
        fast_wait = 16'(`CG_FAST_WAIT_CODE0) >> code;
    endfunction

    // Bit n-1 of a ripple count gives division by 2^n
    function automatic logic div_level(input logic [6:0] cnt, input logic [2:0] n, input logic base);
        div_level = (n == 3'h0) ? base : cnt[3'(n - 3'h1)];
    endfunction

    clock_gen_pkg::state_t st_r;
    clock_gen_pkg::state_t st_nxt;
    logic [1:0] tick;
    logic fast_run;
    logic slow_run;
    logic sys_tick;
    logic [15:0] slow_wait;
    logic [2:0] gear_mask;
    logic [1:0] ch_tick;
    logic [1:0] ch_base;
    logic [1:0] ch_rdy;
    logic [1:0] ch_level;
    logic [1:0] tgt;

    // Oscillator edges from the second and third sampling stages
    assign tick = st_r.s2 & ~st_r.s3;

    // Oscillators run by enable, slow kept in sleep by rtc run
    assign fast_run = st_r.fast_en && (st_r.mode != clock_gen_pkg::MODE_SLEEP);
    assign slow_run = st_r.slow_en && ((st_r.mode != clock_gen_pkg::MODE_SLEEP) || rtc_run_bit);

    assign slow_wait = (st_r.slow_wt == `CG_SLOW_WT_SHORT) ? 16'(SLOW_WAIT_SHORT) : 16'(SLOW_WAIT_LONG);

    // System tick follows the selected, stable source, none in sleep
    always_comb begin
        sys_tick = 1'b0;
        if (st_r.mode != clock_gen_pkg::MODE_SLEEP) begin
            if (st_r.src == `CG_SRC_FAST) begin
                sys_tick = tick[0] & st_r.fast_rdy;
            end else begin
                sys_tick = tick[1] & st_r.slow_rdy;
            end
        end
        // No tick right after another across a source change
        if (st_r.tick_d) begin
            sys_tick = 1'b0;
        end
    end

    // Gear mask selects 1, 2, 4 or 8 system ticks per core tick
    assign gear_mask = 3'((4'h1 << st_r.gear) - 4'h1);

    // Per-channel source, readiness and divided level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ch_tick[i] = 1'b0;
            ch_base[i] = 1'b0;
            ch_rdy[i] = 1'b0;
            // Source choice, reserved codes give no clock
            if (st_r.ch[i].src == `CG_SRC_FAST) begin
                ch_tick[i] = tick[0];
                ch_base[i] = st_r.s2[0];
                ch_rdy[i] = st_r.fast_rdy;
            end else if (st_r.ch[i].src == `CG_SRC_SLOW) begin
                ch_tick[i] = tick[1];
                ch_base[i] = st_r.s2[1];
                ch_rdy[i] = st_r.slow_rdy;
            end
            // Divided level, held low until source stable
            ch_level[i] = ch_rdy[i] & div_level(st_r.ch[i].cnt, st_r.ch[i].div, ch_base[i]);
        end
    end

    assign tgt = reg_req.wdata[`CG_SRC_SEL_LSB +: 2];

    // Next state
    always_comb begin
        st_nxt = st_r;
        // Two-stage sampling, third stage only for edge detection
        st_nxt.s1 = osc_level;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Remember the last system tick for the switch guard
        st_nxt.tick_d = sys_tick;

        // Fast stabilization counted in fast cycles
        if (!fast_run) begin
            st_nxt.fast_cnt = 16'h0000;
            st_nxt.fast_rdy = 1'b0;
        end else if (!st_r.fast_rdy && tick[0]) begin
            if (st_r.fast_cnt >= fast_wait(st_r.fast_wt) - 16'h0001) begin
                st_nxt.fast_rdy = 1'b1;
            end else begin
                st_nxt.fast_cnt = st_r.fast_cnt + 16'h0001;
            end
        end

        // Slow stabilization counted in slow cycles
        if (!slow_run) begin
            st_nxt.slow_cnt = 16'h0000;
            st_nxt.slow_rdy = 1'b0;
        end else if (!st_r.slow_rdy && tick[1]) begin
            if (st_r.slow_cnt >= slow_wait - 16'h0001) begin
                st_nxt.slow_rdy = 1'b1;
            end else begin
                st_nxt.slow_cnt = st_r.slow_cnt + 16'h0001;
            end
        end

        // Gear counter advances on system ticks
        if (sys_tick) begin
            st_nxt.gear_cnt = st_r.gear_cnt + 3'h1;
        end

        // Output counters run on their source once stable
        for (int i = 0; i < 2; i++) begin
            if (!ch_rdy[i]) begin
                st_nxt.ch[i].cnt = 7'h00;
            end else if (ch_tick[i]) begin
                st_nxt.ch[i].cnt = st_r.ch[i].cnt + 7'h01;
            end
        end

        // Register writes
        if (reg_req.we) begin
            case (reg_req.addr)
                `CG_OFS_SRC: begin
                    st_nxt.fsel = reg_req.wdata[`CG_SRC_FSEL_LSB +: 2];
                    // Switch only to an enabled, stable oscillator
                    if ((tgt == `CG_SRC_FAST && st_r.fast_en && st_r.fast_rdy)
                        || (tgt == `CG_SRC_SLOW && st_r.slow_en && st_r.slow_rdy)) begin
                        st_nxt.src = tgt;
                    end
                end
                `CG_OFS_CTL: begin
                    st_nxt.fast_en = reg_req.wdata[`CG_CTL_FAST_EN] | (st_r.src == `CG_SRC_FAST);
                    st_nxt.slow_en = reg_req.wdata[`CG_CTL_SLOW_EN] | (st_r.src == `CG_SRC_SLOW);
                end
                `CG_OFS_OUTA, `CG_OFS_OUTB: begin
                    st_nxt.ch[reg_req.addr[0]].en = reg_req.wdata[`CG_OUT_EN_BIT];
                    st_nxt.ch[reg_req.addr[0]].src = reg_req.wdata[`CG_OUT_SRC_LSB +: 2];
                    st_nxt.ch[reg_req.addr[0]].div = reg_req.wdata[`CG_OUT_DIV_LSB +: 3];
                end
                `CG_OFS_WAIT: begin
                    st_nxt.fast_wt = reg_req.wdata[`CG_WAIT_FAST_LSB +: 2];
                    st_nxt.slow_wt = reg_req.wdata[`CG_WAIT_SLOW_LSB +: 2];
                end
                `CG_OFS_PCLK: st_nxt.pclk = reg_req.wdata[1:0];
                `CG_OFS_CORE_CLOCK: st_nxt.gear = reg_req.wdata[1:0];
                default: ;
            endcase
        end

        // Power mode sequencing
        case (st_r.mode)
            clock_gen_pkg::MODE_RUN: begin
                if (sleep_req) begin
                    st_nxt.mode = clock_gen_pkg::MODE_SLEEP;
                end else if (halt_req) begin
                    // Halt stops only the core clock
                    st_nxt.mode = clock_gen_pkg::MODE_HALT;
                end
            end
            clock_gen_pkg::MODE_HALT: begin
                if (irq_wake || ext_wake) begin
                    st_nxt.mode = clock_gen_pkg::MODE_RUN;
                end
            end
            clock_gen_pkg::MODE_SLEEP: begin
                // External wake restarts on the fast oscillator
                if (ext_wake) begin
                    st_nxt.mode = clock_gen_pkg::MODE_RUN;
                    st_nxt.fast_en = 1'b1;
                    st_nxt.src = `CG_SRC_FAST;
                end
            end
            default: st_nxt.mode = clock_gen_pkg::MODE_RUN;
        endcase

        // Read data, valid the cycle after the strobe
        st_nxt.rdata = 8'h00;
        if (reg_req.re) begin
            case (reg_req.addr)
                `CG_OFS_SRC: st_nxt.rdata = {st_r.fsel, 4'h0, st_r.src};
                `CG_OFS_CTL: st_nxt.rdata = {5'h00, st_r.fast_en, st_r.slow_en, 1'b0};
                `CG_OFS_OUTA, `CG_OFS_OUTB: st_nxt.rdata = {1'b0, st_r.ch[reg_req.addr[0]].div,
                    st_r.ch[reg_req.addr[0]].src, 1'b0, st_r.ch[reg_req.addr[0]].en};
                `CG_OFS_WAIT: st_nxt.rdata = {2'h0, st_r.slow_wt, 2'h0, st_r.fast_wt};
                `CG_OFS_PCLK: st_nxt.rdata = {6'h00, st_r.pclk};
                `CG_OFS_CORE_CLOCK: st_nxt.rdata = {6'h00, st_r.gear};
                `CG_OFS_STAT: st_nxt.rdata = {4'h0, st_r.mode == clock_gen_pkg::MODE_SLEEP,
                    st_r.mode == clock_gen_pkg::MODE_HALT, st_r.slow_rdy, st_r.fast_rdy};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= '0;
            // Fast oscillator selected and enabled after reset
            st_r.src <= `CG_SRC_FAST;
            st_r.fast_en <= 1'b1;
            st_r.slow_en <= 1'b0;
            st_r.fast_wt <= `CG_FAST_WT_RST;
            st_r.slow_wt <= `CG_SLOW_WT_RST;
            st_r.pclk <= `CG_PCLK_RST;
            st_r.gear <= `CG_GEAR_RST;
            st_r.mode <= clock_gen_pkg::MODE_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Ticks and oscillator controls
    assign sys_clk_tick = sys_tick;
    // Core tick on every 2^gear system ticks, none in halt
    assign core_clock_tick = sys_tick && ((st_r.gear_cnt & gear_mask) == 3'h0)
        && (st_r.mode == clock_gen_pkg::MODE_RUN);
    // Peripheral tick is the gated system tick
    assign periph_clk_tick = sys_tick && (st_r.pclk == `CG_PCLK_ON);
    // Timer tick from the slow oscillator, free of the gate
    assign slow_timer_tick = tick[1] & st_r.slow_rdy;
    assign fast_osc_run = fast_run;
    assign slow_osc_run = slow_run;
    assign fast_osc_freq_sel = st_r.fsel;
    assign reg_rdata = st_r.rdata;

    // Pins follow the enable bit directly
    assign clk_out_a.level = st_r.ch[0].en & ch_level[0];
    assign clk_out_a.oe = st_r.ch[0].en;
    assign clk_out_b.level = st_r.ch[1].en & ch_level[1];
    assign clk_out_b.oe = st_r.ch[1].en;

endmodule // clock_gen

`default_nettype wire

// >>> design/clock_gen_regs.svh
// Register offsets, field positions, reset values and wait counts of the clock generator.
// Assumes an 8-bit register port whose byte offsets are relative to the block base.
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH

// Register offsets
`define CG_OFS_SRC 8'h00
`define CG_OFS_CTL 8'h01
`define CG_OFS_OUTA 8'h04
`define CG_OFS_OUTB 8'h05
`define CG_OFS_WAIT 8'h1D
`define CG_OFS_PCLK 8'h20
`define CG_OFS_CORE_CLOCK 8'h21
`define CG_OFS_STAT 8'h22

// Field positions
`define CG_SRC_SEL_LSB 0
`define CG_SRC_FSEL_LSB 6
`define CG_CTL_FAST_EN 2
`define CG_CTL_SLOW_EN 1
`define CG_OUT_EN_BIT 0
`define CG_OUT_SRC_LSB 2
`define CG_OUT_DIV_LSB 4
`define CG_WAIT_FAST_LSB 0
`define CG_WAIT_SLOW_LSB 4

// Codes and reset values
`define CG_SRC_FAST 2'h0
`define CG_SRC_SLOW 2'h1
`define CG_PCLK_ON 2'h3
`define CG_PCLK_RST 2'h3
`define CG_GEAR_RST 2'h0
`define CG_FAST_WT_RST 2'h0
`define CG_SLOW_WT_RST 2'h0
`define CG_SLOW_WT_SHORT 2'h2

// Stabilization counts in oscillator cycles
`define CG_FAST_WAIT_CODE0 64
`define CG_SLOW_WAIT_LONG 16384
`define CG_SLOW_WAIT_SHORT 4096

`endif

// >>> design/clock_gen_pkg.sv
// Types shared by the clock generator and its surroundings.
// Assumes clock_gen_regs.svh supplies the numeric constants.
package clock_gen_pkg;

    // Power mode of the core
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_HALT,
        MODE_SLEEP
    } power_t;

    // Register port request
    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Clock output pin: level and output enable
    typedef struct packed {
        logic level;
        logic oe;
    } clk_pin_t;

    // One clock output channel
    typedef struct packed {
        logic [1:0] src;
        logic [2:0] div;
        logic en;
        logic [6:0] cnt;
    } out_ch_t;

    // Whole state of the block
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] fsel;
        logic [1:0] src;
        logic fast_en;
        logic slow_en;
        logic [1:0] fast_wt;
        logic [1:0] slow_wt;
        logic [1:0] pclk;
        logic [1:0] gear;
        logic [15:0] fast_cnt;
        logic [15:0] slow_cnt;
        logic fast_rdy;
        logic slow_rdy;
        logic [2:0] gear_cnt;
        out_ch_t [1:0] ch;
        power_t mode;
        logic [7:0] rdata;
        logic tick_d;
    } state_t;

endpackage

// >>> test/clock_gen_props.sv
// Checker for the clock generator: tick, read port and pin relations.
// Assumes one clock domain, clk_sys, and the synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire clock_gen_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Power control
    input wire logic halt_req,
    input wire logic sleep_req,
    input wire logic irq_wake,
    input wire logic ext_wake,
    // Oscillators and ticks
    input wire logic fast_osc_run,
    input wire logic slow_osc_run,
    input wire logic sys_clk_tick,
    input wire logic core_clock_tick,
    input wire logic periph_clk_tick,
    input wire logic slow_timer_tick,
    // Clock output pins
    input wire clock_gen_pkg::clk_pin_t clk_out_a,
    input wire clock_gen_pkg::clk_pin_t clk_out_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_core_from_sys: assert property (core_clock_tick |-> sys_clk_tick)
        else $error("core tick without system tick");
    a_periph_from_sys: assert property (periph_clk_tick |-> sys_clk_tick)
        else $error("peripheral tick without system tick");
    a_halt_core_stop: assert property ((halt_req || sleep_req) && !irq_wake && !ext_wake |=> !core_clock_tick)
        else $error("core tick after halt");
    a_tick_needs_osc: assert property (sys_clk_tick |-> fast_osc_run || slow_osc_run)
        else $error("system tick with oscillators off");
    a_sys_single: assert property (sys_clk_tick |=> !sys_clk_tick)
        else $error("system tick too short apart");
    a_slow_single: assert property (slow_timer_tick |=> !slow_timer_tick)
        else $error("slow tick too short apart");
    a_reset_fast_on: assert property ($fell(reset) |-> fast_osc_run)
        else $error("fast oscillator off after reset");
    a_outa_off_low: assert property (!clk_out_a.oe |-> !clk_out_a.level)
        else $error("output a drives while disabled");
    a_outb_off_low: assert property (!clk_out_b.oe |-> !clk_out_b.level)
        else $error("output b drives while disabled");
    a_rdata_idle: assert property (!$past(reg_req.re) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    // Main scenarios reached
    c_core: cover property (core_clock_tick);
    c_periph: cover property (periph_clk_tick);
    c_outb: cover property ($rose(clk_out_b.level));
endmodule // clock_gen_props
bind clock_gen clock_gen_props u_props (.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .halt_req(halt_req), .sleep_req(sleep_req), .irq_wake(irq_wake),
    .ext_wake(ext_wake), .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run),
    .sys_clk_tick(sys_clk_tick), .core_clock_tick(core_clock_tick), .periph_clk_tick(periph_clk_tick),
    .slow_timer_tick(slow_timer_tick), .clk_out_a(clk_out_a), .clk_out_b(clk_out_b));
`default_nettype wire

// >>> test/osc_model.sv
// Oscillator model: fast and slow sources that stand still while off.
// Assumes run controls come from the clock generator.
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
    parameter int FAST_HALF = 20,
    parameter int SLOW_HALF = 100
) (
    // Run controls
    input wire logic fast_run,
    input wire logic slow_run,
    // Levels, bit 0 fast, bit 1 slow
    output logic [1:0] osc_level
);
    logic fast_lvl = 1'b0;
    logic slow_lvl = 1'b0;
    always #(FAST_HALF) fast_lvl = fast_run ? ~fast_lvl : 1'b0;
    always #(SLOW_HALF) slow_lvl = slow_run ? ~slow_lvl : 1'b0;
    // Levels handed to the generator, one driver each
    assign osc_level = {slow_lvl, fast_lvl};
endmodule // osc_model
`default_nettype wire

// >>> test/clock_gen_tb.sv
// Testbench of the clock generator: registers, gear, gate, power modes, outputs.
// Assumes osc_model drives the oscillator levels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; $display("Error %s exp %0h got %0h", n, e, a); end end
module clock_gen_tb;
    logic clk_sys, reset, rtc_run_bit;
    logic [3:0] pw;
    clock_gen_pkg::reg_req_t reg_req;
    clock_gen_pkg::clk_pin_t clk_out_a, clk_out_b;
    logic [7:0] reg_rdata, d;
    logic [1:0] osc_level, fsel;
    logic fast_osc_run, slow_osc_run, sys_clk_tick, core_clock_tick, periph_clk_tick, slow_timer_tick;
    logic [31:0] rnd = 32'h9CCD0298;
    int err_count = 0, checked = 0, s, c, p, oa, ob, x, e;
    clock_gen #(.SLOW_WAIT_LONG(32), .SLOW_WAIT_SHORT(8)) uut (.clk_sys(clk_sys), .reset(reset),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .osc_level(osc_level), .fast_osc_run(fast_osc_run),
        .slow_osc_run(slow_osc_run), .fast_osc_freq_sel(fsel), .halt_req(pw[0]), .sleep_req(pw[2]),
        .irq_wake(pw[1]), .ext_wake(pw[3]), .rtc_run_bit(rtc_run_bit), .sys_clk_tick(sys_clk_tick),
        .core_clock_tick(core_clock_tick), .periph_clk_tick(periph_clk_tick),
        .slow_timer_tick(slow_timer_tick), .clk_out_a(clk_out_a), .clk_out_b(clk_out_b));
    osc_model osc (.fast_run(fast_osc_run), .slow_run(slow_osc_run), .osc_level(osc_level));
    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic hang;
        err_count++;
        complete_run();
    endtask
    // One-cycle register write and read
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        reg_req <= '0;
        #1 d = reg_rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] v, input string n);
        rd(a);
        `CHK(n, v, d)
    endtask
    // One-cycle power control pulse
    task automatic pulse(input int k);
        @(posedge clk_sys);
        pw[k] <= 1'b1;
        @(posedge clk_sys);
        pw[k] <= 1'b0;
    endtask
    task automatic wait_rdy(input int b);
        int i;
        d = 8'h00;
        for (i = 0; i < 2000 && !d[b]; i++) rd(8'h22);
        if (!d[b]) hang();
    endtask
    // Counts ticks and output edges over n reference ticks
    task automatic cnt(input int n, input bit sl, input int lim);
        int t;
        logic la, lb;
        s = 0; c = 0; p = 0; oa = 0; ob = 0;
        la = clk_out_a.level;
        lb = clk_out_b.level;
        for (t = 0; t < lim && s < n; t++) begin
            @(posedge clk_sys);
            #1;
            s += sl ? slow_timer_tick : sys_clk_tick;
            c += core_clock_tick;
            p += periph_clk_tick;
            oa += clk_out_a.level & ~la;
            ob += clk_out_b.level & ~lb;
            la = clk_out_a.level;
            lb = clk_out_b.level;
        end
        if (s < n && lim > 500) hang();
    endtask
    initial begin
        clk_sys = 0; reset = 1; reg_req = '0; pw = 4'h0; rtc_run_bit = 0;
        repeat (20) @(posedge clk_sys);
        reset <= 0;
        rc(8'h00, 8'h00, "src");
        rc(8'h01, 8'h04, "ctl");
        rc(8'h20, 8'h03, "gate");
        rc(8'h21, 8'h00, "gear");
        rc(8'h04, 8'h00, "out");
        rc(8'h10, 8'h00, "unmapped");
        wait_rdy(0);
        for (x = 0; x < 4; x++) begin
            wr(8'h21, 8'(x));
            cnt(16, 0, 20000);
            `CHK("core", 16 >> x, c)
            `CHK("periph", 16, p)
        end
        wr(8'h21, 8'h00);
        // only gate codes 0 and 3 are written
        wr(8'h20, 8'h00);
        cnt(16, 0, 20000);
        `CHK("gate off", 0, p)
        wr(8'h20, 8'h03);
        $display("test gear and gate done");
        wr(8'h00, 8'h01);
        rc(8'h00, 8'h00, "src refused");
        wr(8'h01, 8'h00);
        rc(8'h01, 8'h04, "ctl kept");
        wr(8'h1D, 8'h20);
        wr(8'h01, 8'h06);
        wait_rdy(1);
        wr(8'h00, 8'h01);
        @(posedge clk_sys);
        rc(8'h00, 8'h01, "src slow");
        wr(8'h01, 8'h02);
        rc(8'h01, 8'h02, "fast off");
        $display("test switching done");
        pulse(0);
        cnt(8, 0, 20000);
        `CHK("halt core", 0, c)
        pulse(1);
        cnt(8, 0, 20000);
        `CHK("wake core", 8, c)
        rc(8'h00, 8'h01, "halt src");
        rc(8'h01, 8'h02, "halt ctl");
        $display("test halt done");
        // short fast wait, enable, then select fast
        wr(8'h1D, 8'h23);
        wr(8'h01, 8'h06);
        wait_rdy(0);
        wr(8'h00, 8'h40);
        @(posedge clk_sys);
        rc(8'h00, 8'h40, "src fast");
        `CHK("fsel pin", 2'h1, fsel)
        wr(8'h00, 8'h01);
        wr(8'h01, 8'h02);
        rc(8'h01, 8'h02, "back slow");
        $display("test return to fast done");
        pulse(2);
        cnt(1, 0, 300);
        `CHK("sleep sys", 0, s)
        `CHK("sleep slow", 1'b0, slow_osc_run)
        pulse(3);
        rc(8'h00, 8'h00, "wake src");
        rc(8'h01, 8'h06, "wake ctl");
        cnt(8, 0, 20000);
        `CHK("wake sys", 8, s)
        $display("test sleep done");
        // Sleep with rtc run: slow keeps running, timers keep ticking
        wait_rdy(1);
        wr(8'h00, 8'h01);
        wr(8'h01, 8'h02);
        rtc_run_bit <= 1'b1;
        pulse(2);
        cnt(4, 1, 2000);
        `CHK("rtc slow", 1'b1, slow_osc_run)
        `CHK("rtc timer", 4, s)
        `CHK("rtc core", 0, c)
        pulse(3);
        rc(8'h01, 8'h06, "rtc wake ctl");
        rc(8'h00, 8'h00, "rtc wake src");
        rtc_run_bit <= 1'b0;
        $display("test rtc sleep done");
        // pin function is selected outside this block
        for (x = 0; x < 2; x++) begin
            rnd = xs(rnd);
            wr(8'h04 + 8'(x), {1'b0, rnd[2:0], 2'(x), 2'b01});
            cnt(256, x[0], 20000);
            e = (x ? ob : oa) - (256 >> rnd[2:0]);
            `CHK("div edges", 1'b1, e >= -1 && e <= 1)
            `CHK("oe", 1'b1, x ? clk_out_b.oe : clk_out_a.oe)
            wr(8'h04 + 8'(x), 8'h00);
            @(posedge clk_sys);
            #1;
            `CHK("off pin", 2'b00, x ? clk_out_b : clk_out_a)
        end
        $display("test outputs done");
        complete_run();
    end
endmodule // clock_gen_tb
`default_nettype wire
